// ===== pkg/sar_consts.svh
// Timing counts and code values for the converter control block.
`ifndef SAR_CONSTS_SVH
`define SAR_CONSTS_SVH
`define CLK_PERIOD_NS 25
`define CONV_TIME_NS 650
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_TIME_NS 20
`define WAKE_CYCLES ((`WAKE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESULT_W 16
`define LOW_FILL 8'hff
`define RESULT_RESET 16'h0000
`endif

// ===== pkg/sar_pkg.sv
// Types shared by the converter control block.
package sar_pkg;
  typedef enum logic [1:0] {ST_WAKE, ST_SAMPLE, ST_CONVERT, ST_IDLE} phase_t;
  typedef struct packed {
    logic chip_sel_n;
    logic read_enable_n;
    logic half_select;
  } read_ctl_t;
endpackage : sar_pkg

// ===== hdl/sar_adc_conversion_readout.sv
// Conversion sequencing and parallel readout of a 16-bit SAR converter.
`timescale 1ns/100ps
`include "sar_consts.svh"
module sar_adc_conversion_readout
  import sar_pkg::*;
#(
  parameter int CONV_CYCLES = `CONV_CYCLES,
  parameter int WAKE_CYCLES = `WAKE_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic conversion_start_n,
  input wire read_ctl_t read_ctl,
  input wire logic [`RESULT_W-1:0] sample_code,
  output logic busy,
  output logic sampling,
  output logic [`RESULT_W-1:0] out_bus_o,
  output logic [`RESULT_W-1:0] out_bus_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection on the start pin.

  logic start_n_q;
  logic cs_n_q;
  phase_t phase_q;
  phase_t phase_d;
  logic [9:0] cnt_q;
  logic [9:0] cnt_d;
  logic [`RESULT_W-1:0] held_q;
  logic [`RESULT_W-1:0] latch_q;
  logic [9:0] busy_len_q;

  wire start_fall = start_n_q & ~conversion_start_n;
  // Start is honoured only while the chip is selected.
  wire start_ok = start_fall & ~read_ctl.chip_sel_n;
  wire cs_fall = cs_n_q & ~read_ctl.chip_sel_n;
  wire converting = (phase_q == ST_CONVERT);
  // A start during the wake phase is ignored, so only these phases accept one.
  wire can_start = (phase_q == ST_SAMPLE) | (phase_q == ST_IDLE);
  wire start_go = start_ok & can_start;
  // A start while converting aborts like a pin reset, restarting the wake.
  wire self_clear = start_ok & converting;
  wire conv_done = converting & (cnt_q == 10'(CONV_CYCLES - 1));

  // Busy and sampling are decoded straight from the registered phase, clocked by clk.
  assign busy = converting;
  assign sampling = (phase_q == ST_SAMPLE);

  ////////////////////////////////////////////////////////////////////////////
  // Phase sequencing.

  // Next phase and the shared cycle counter.
  always_comb begin
    phase_d = phase_q;
    cnt_d = cnt_q + 10'h001;
    case (phase_q)
      ST_WAKE: begin
        if (cnt_q == 10'(WAKE_CYCLES - 1)) begin
          phase_d = ST_SAMPLE;
        end
      end
      ST_SAMPLE, ST_IDLE: begin
        if (start_ok) begin
          phase_d = ST_CONVERT;
          cnt_d = 10'h000;
        end else if (phase_q == ST_IDLE && cs_fall) begin
          phase_d = ST_SAMPLE;
        end
      end
      ST_CONVERT: begin
        if (self_clear) begin
          phase_d = ST_WAKE;
          cnt_d = 10'h000;
        end else if (conv_done) begin
          // Selected chip resumes sampling at once; else waits for cs fall.
          phase_d = read_ctl.chip_sel_n ? ST_IDLE : ST_SAMPLE;
        end
      end
      default: begin
        phase_d = ST_WAKE;
        cnt_d = 10'h000;
      end
    endcase
    if (phase_d == ST_SAMPLE || phase_d == ST_IDLE) begin
      cnt_d = 10'h000;
    end
  end

  // Phase state; the asynchronous reset aborts any conversion.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_q <= ST_WAKE;
      cnt_q <= 10'h000;
      start_n_q <= 1'b1;
      cs_n_q <= 1'b1;
    end else begin
      phase_q <= phase_d;
      cnt_q <= cnt_d;
      start_n_q <= conversion_start_n;
      cs_n_q <= read_ctl.chip_sel_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hold capture and output latch.

  // The code is frozen at the start edge and published when busy falls,
  // so reads see the last complete conversion, or zero after an abort or reset.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      held_q <= `RESULT_RESET;
      latch_q <= `RESULT_RESET;
    end else begin
      if (start_go) begin
        held_q <= sample_code;
      end
      if (self_clear) begin
        latch_q <= `RESULT_RESET;
      end else if (conv_done) begin
        latch_q <= held_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readout bus.

  wire bus_en = ~read_ctl.chip_sel_n & ~read_ctl.read_enable_n;
  // Byte order selection follows the select pin live, so held-low reads work.
  assign out_bus_o = read_ctl.half_select
    ? {latch_q[7:0], `LOW_FILL}
    : latch_q;
  assign out_bus_oe_n = {`RESULT_W{~bus_en}};

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  // Counts busy cycles, since a repetition cannot cover a full conversion.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_len_q <= 10'h000;
    end else begin
      busy_len_q <= busy ? busy_len_q + 10'h001 : 10'h000;
    end
  end

  property p_drive;
    @(posedge clk) disable iff (!arst_n)
      (out_bus_oe_n == 16'h0000)
        == (!read_ctl.chip_sel_n && !read_ctl.read_enable_n);
  endproperty
  a_drive: assert property (p_drive) else $error("bus enable wrong");

  property p_busy_rise;
    @(posedge clk) disable iff (!arst_n)
      start_go |=> busy;
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy late");

  property p_conv_len;
    @(posedge clk) disable iff (!arst_n)
      $fell(busy) && !$past(self_clear) |-> busy_len_q == 10'(CONV_CYCLES);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("busy short");

  property p_conv_end;
    @(posedge clk) disable iff (!arst_n)
      $rose(busy) |-> ##[1:30] !busy;
  endproperty
  a_conv_end: assert property (p_conv_end) else $error("busy stuck");

  property p_latch;
    @(posedge clk) disable iff (!arst_n)
      conv_done && !self_clear |=> latch_q == $past(held_q);
  endproperty
  a_latch: assert property (p_latch) else $error("latch miss");

  property p_half;
    @(posedge clk) disable iff (!arst_n)
      read_ctl.half_select |-> out_bus_o[7:0] == 8'hff
        && out_bus_o[15:8] == latch_q[7:0];
  endproperty
  a_half: assert property (p_half) else $error("byte mode wrong");

  property p_full;
    @(posedge clk) disable iff (!arst_n)
      !read_ctl.half_select |-> out_bus_o == latch_q;
  endproperty
  a_full: assert property (p_full) else $error("word mode wrong");

  property p_abort;
    @(posedge clk) disable iff (!arst_n)
      self_clear |=> !busy && latch_q == 16'h0000;
  endproperty
  a_abort: assert property (p_abort) else $error("abort failed");

  property p_resample;
    @(posedge clk) disable iff (!arst_n)
      conv_done && !self_clear && !read_ctl.chip_sel_n |=> sampling;
  endproperty
  a_resample: assert property (p_resample) else $error("no resample");

  c_conv: cover property (@(posedge clk) disable iff (!arst_n) $fell(busy));
  c_abort: cover property (@(posedge clk) disable iff (!arst_n) self_clear);
  c_byte: cover property (@(posedge clk) disable iff (!arst_n)
    bus_en && read_ctl.half_select);
  c_idle: cover property (@(posedge clk) disable iff (!arst_n)
    (phase_q == ST_IDLE) && cs_fall);

endmodule : sar_adc_conversion_readout

// ===== verif/host_model.sv
// Host model driving the start pin and the read controls.
`timescale 1ns/100ps
module host_model
  import sar_pkg::*;
(
  input wire logic clk,
  output logic conversion_start_n,
  output read_ctl_t read_ctl
);
  // Start idles high with the chip selected and no read.
  initial begin
    conversion_start_n = 1'b1;
    read_ctl = '{1'b0, 1'b1, 1'b0};
  end
  // Two cycles low is 50 ns, safely above the minimum.
  task automatic start(input logic cs_n);
    @(posedge clk);
    #2;
    read_ctl = '{cs_n, 1'b1, 1'b0}; // Reads stay off near the edge.
    repeat (2) @(posedge clk);
    #2;
    conversion_start_n = 1'b0;
    repeat (2) @(posedge clk);
    #2;
    conversion_start_n = 1'b1;
    read_ctl.chip_sel_n = 1'b0;
  endtask : start
  // Read controls change just after an edge.
  task automatic rd(input logic cs_n, input logic rd_n, input logic half);
    @(posedge clk);
    #2;
    read_ctl = '{cs_n, rd_n, half};
    // The bus mux is live, so let it settle before the caller looks.
    #1;
  endtask : rd
endmodule : host_model

// ===== verif/tb_top.sv
// Self-checking bench for the converter control block.
`timescale 1ns/100ps
`include "sar_consts.svh"
module tb_top;
  logic clk;
  logic arst_n;
  logic busy;
  logic sampling;
  logic conversion_start_n;
  logic [15:0] sample_code;
  logic [15:0] out_bus_o;
  logic [15:0] out_bus_oe_n;
  sar_pkg::read_ctl_t read_ctl;
  int err_count = 0;
  int comparisons = 0;
  host_model u_host_model(.clk(clk), .conversion_start_n(conversion_start_n),
    .read_ctl(read_ctl));
  sar_adc_conversion_readout
    u_sar_adc_conversion_readout(.clk(clk), .arst_n(arst_n),
    .conversion_start_n(conversion_start_n), .read_ctl(read_ctl),
    .sample_code(sample_code), .busy(busy), .sampling(sampling),
    .out_bus_o(out_bus_o), .out_bus_oe_n(out_bus_oe_n));
  // Free-running 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string what, input logic [15:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic conclude();
    if (err_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  // Full conversion; the input changes after the hold edge on purpose.
  task automatic conv(input logic [15:0] code);
    int n;
    sample_code = code;
    u_host_model.start(1'b0);
    sample_code = ~code;
    chk("busy", 16'h1, {15'h0, busy});
    chk("sampling", 16'h0, {15'h0, sampling});
    n = 1;
    while (busy === 1'b1 && n < 40) begin
      @(posedge clk);
      #2;
      n++;
    end
    chk("busy cycles", 16'(`CONV_CYCLES), n[15:0]);
    chk("sampling", 16'h1, {15'h0, sampling});
    if (n >= 40) conclude();
  endtask : conv
  task automatic power_up();
    repeat (3) @(posedge clk);
    #2 arst_n = 1'b1;
    repeat (2) @(posedge clk);
    #2 chk("sampling", 16'h1, {15'h0, sampling});
    u_host_model.rd(1'b0, 1'b0, 1'b0);
    chk("out", 16'h0000, out_bus_o);
  endtask : power_up
  // Boundary codes read as a word, then as bytes with read held low.
  task automatic codes();
    logic [15:0] c [4] = '{16'hffff, 16'h8000, 16'h0000, 16'h7fff};
    foreach (c[i]) begin
      conv(c[i]);
      u_host_model.rd(1'b0, 1'b0, 1'b0);
      chk("word", c[i], out_bus_o);
      chk("oe_n", 16'h0000, out_bus_oe_n);
      u_host_model.rd(1'b0, 1'b0, 1'b1);
      chk("byte", {c[i][7:0], 8'hff}, out_bus_o);
      u_host_model.rd(1'b0, 1'b1, 1'b1);
      u_host_model.rd(1'b0, 1'b0, 1'b1);
      chk("byte", {c[i][7:0], 8'hff}, out_bus_o);
      for (int k = 1; k < 4; k++) begin
        u_host_model.rd(k[1], k[0], 1'b0);
        chk("oe_n", 16'hffff, out_bus_oe_n);
      end
    end
  endtask : codes
  task automatic no_cs();
    u_host_model.start(1'b1);
    chk("busy", 16'h0, {15'h0, busy});
    u_host_model.rd(1'b0, 1'b0, 1'b0);
    chk("word", 16'h7fff, out_bus_o);
  endtask : no_cs
  // Deselected at the end of a conversion, sampling waits for select.
  task automatic deselect();
    int n;
    u_host_model.start(1'b0);
    u_host_model.rd(1'b1, 1'b1, 1'b0);
    n = 0;
    while (busy === 1'b1 && n < 40) begin
      @(posedge clk);
      #2;
      n++;
    end
    chk("busy", 16'h0, {15'h0, busy});
    chk("sampling", 16'h0, {15'h0, sampling});
    u_host_model.rd(1'b0, 1'b1, 1'b0);
    @(posedge clk);
    #2 chk("sampling", 16'h1, {15'h0, sampling});
  endtask : deselect
  // Pin reset in mid-conversion aborts it and clears the result.
  task automatic reset_mid();
    u_host_model.start(1'b0);
    arst_n = 1'b0;
    #5 chk("busy", 16'h0, {15'h0, busy});
    u_host_model.rd(1'b0, 1'b0, 1'b0);
    chk("word", 16'h0000, out_bus_o);
    @(posedge clk);
    #2 arst_n = 1'b1;
    repeat (2) @(posedge clk);
    #2 chk("sampling", 16'h1, {15'h0, sampling});
  endtask : reset_mid
  task automatic abort_mid();
    conv(16'hbeef);
    u_host_model.start(1'b0);
    repeat (5) @(posedge clk);
    u_host_model.start(1'b0);
    chk("busy", 16'h0, {15'h0, busy});
    u_host_model.rd(1'b0, 1'b0, 1'b0);
    chk("word", 16'h0000, out_bus_o);
  endtask : abort_mid
  initial begin
    arst_n = 1'b0;
    sample_code = 16'h0000;
    power_up();
    codes();
    no_cs();
    deselect();
    reset_mid();
    abort_mid();
    conclude();
  end
  // Cuts a hang short.
  initial begin
    #100000;
    err_count++;
    conclude();
  end
endmodule : tb_top
